// ### logic/ulp_defs.vh
// Register offsets, field positions, reset values and timing constants of the low power block
`ifndef ULP_DEFS_VH
`define ULP_DEFS_VH

`define ULP_ADDR_W             12
`define ULP_FUNC_CTRL_OFS      12'h000
`define ULP_OTG_CTRL_OFS       12'h004
`define ULP_IRQ_RISE_EN_OFS    12'h008
`define ULP_IRQ_FALL_EN_OFS    12'h00C
`define ULP_IFC_CTRL_OFS       12'h010
`define ULP_STATUS_OFS         12'h014

`define ULP_FUNC_SPEED_LSB     0
`define ULP_FUNC_TERM_BIT      2
`define ULP_FUNC_OPMODE_LSB    3
`define ULP_FUNC_AWAKE_BIT     6
`define ULP_FUNC_CTRL_RST      8'h41
`define ULP_OPMODE_HIGH_Z      2'h1

`define ULP_OTG_DP_PD_BIT      1
`define ULP_OTG_DM_PD_BIT      2
`define ULP_OTG_ID_RISE_BIT    3
`define ULP_OTG_ID_FALL_BIT    4
`define ULP_OTG_CTRL_RST       8'h06

`define ULP_IRQ_BUSVLD_BIT     0
`define ULP_IRQ_SESSION_VALID_CMP_BIT    1
`define ULP_IRQ_SESSION_END_CMP_BIT    2
`define ULP_IRQ_ID_GROUNDED_CMP_BIT      3
`define ULP_IRQ_EN_RST         4'hF

`define ULP_IFC_PULLUP_DIS_BIT 7
`define ULP_IFC_CTRL_RST       8'h00

`define ULP_REF_CLK_PERIOD_NS  10
`define ULP_ENTRY_EDGES        5
`define ULP_WAKE_EDGES         1
`define ULP_START_TIME_NS      1000
`define ULP_TXCMD_CODE         2'h1

`endif

// ### logic/ulp_clk_out.v
// Divided output clock that can be stopped low, with a pulse on each rising edge
`timescale 1ns/1ps
module ulp_clk_out #(
    parameter HALF_PERIOD = 1
) (
    input  wire       clk,
    input  wire       rstN,
    input  wire       run,
    output reg        phyClk,
    output reg        riseTick
);
    reg [7:0] halfCnt;

    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            phyClk   <= 1'b0;
            riseTick <= 1'b0;
            halfCnt  <= 8'h00;
        end else if (!run) begin
            // Stopping always parks the clock low, even mid high phase
            phyClk   <= 1'b0;
            riseTick <= 1'b0;
            halfCnt  <= 8'h00;
        end else if (halfCnt == HALF_PERIOD[7:0] - 8'h01) begin
            phyClk   <= ~phyClk;
            riseTick <= ~phyClk;
            halfCnt  <= 8'h00;
        end else begin
            riseTick <= 1'b0;
            halfCnt  <= halfCnt + 8'h01;
        end
    end
endmodule

// ### logic/ulp_cmp_irq.v
// Comparator change detector against levels captured before the bus turned over
`timescale 1ns/1ps
module ulp_cmp_irq #(
    parameter N = 4
) (
    input  wire         clk,
    input  wire         rstN,
    input  wire         capture,
    input  wire [N-1:0] cmpLevel,
    input  wire [N-1:0] riseEn,
    input  wire [N-1:0] fallEn,
    output wire         irq
);
    reg  [N-1:0] snap;
    wire [N-1:0] hit;

    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            snap <= {N{1'b0}};
        end else if (capture) begin
            snap <= cmpLevel;
        end
    end

    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : gCmp
            // Combinational so it works with every clock stopped
            assign hit[i] = (cmpLevel[i] & ~snap[i] & riseEn[i]) |
                            (~cmpLevel[i] & snap[i] & fallEn[i]);
        end
    endgenerate

    assign irq = |hit;
endmodule

// ### logic/ulp_low_power_ctrl.v
// Low power entry, exit and interface protection of the transceiver link side
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "ulp_defs.vh"

// Operation
// - After the write, raise DIR, give five clock rising edges, then stop clock low.
// - Low power bus: line state on bits 1:0, interrupt on bit 3, rest low.
// - Interrupt on enabled rising or falling change of the four comparators.
// - Low power bus is driven combinationally, straight from the line receiver.
// - STP high in low power: start-up, restart clock, then drop DIR.
// - Leaving low power sets the awake bit back to one.
// - STP falling before DIR falls is a false resume: back to low power.
// - Link drives bus while DIR low, PHY while high, one turnaround cycle.
// - Non-idle bus after DIR falls may start transmit until STP.
// - STP pull-up on at power-on; interface control bit 7 turns it off.
// - Reset pin low keeps the protection circuit and pull-up off.
// - STP high in low power, by link or pull-up, wakes the PHY.
// - Bus-valid and session-end comparators off only when both enables clear.
module ulp_low_power_ctrl #(
    parameter CLK_HALF_PERIOD = 1,
    parameter START_TIME_NS   = `ULP_START_TIME_NS
) (
    input  wire                   ref_clk,
    input  wire                   reset_n,
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [`ULP_ADDR_W-1:0] paddr,
    input  wire [31:0]            pwdata,
    output wire                   pready,
    output reg  [31:0]            prdata,
    output wire                   pslverr,
    input  wire                   stpIn,
    input  wire [7:0]             dataIn,
    output reg                    dirOut,
    output wire [7:0]             dataOut,
    output wire                   dataOe,
    output wire                   phyClockOut,
    input  wire [1:0]             fsLineState,
    input  wire                   busPowerValidCmp,
    input  wire                   sessionValidCmp,
    input  wire                   sessionEndCmp,
    input  wire                   idGroundedCmp,
    input  wire                   chipResetN,
    output wire                   stopPullupEn,
    output wire                   busPowerCmpEn,
    output wire                   sessionEndCmpEn,
    output wire                   analogPowerDown,
    output wire [1:0]             transceiverSpeedSelect,
    output wire                   terminationSelect,
    output wire [1:0]             opMode,
    output wire                   lineHighZ,
    output wire                   plusLinePulldownEn,
    output wire                   minusLinePulldownEn,
    output reg                    txActive
);
    localparam ST_SYNC    = 3'd0;
    localparam ST_ENTRY   = 3'd1;
    localparam ST_LOWPWR  = 3'd2;
    localparam ST_START   = 3'd3;
    localparam ST_CLKUP   = 3'd4;
    localparam ST_WAITSTP = 3'd5;

    localparam START_CYCLES_RAW = (START_TIME_NS + `ULP_REF_CLK_PERIOD_NS - 1) /
                                  `ULP_REF_CLK_PERIOD_NS;
    localparam START_CYCLES     = (START_CYCLES_RAW < 1) ? 1 : START_CYCLES_RAW;

    reg  [1:0]  rstSync;
    wire        rstN;
    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [7:0]  funcCtrl;
    reg  [7:0]  otgCtrl;
    reg  [3:0]  irqRiseEn;
    reg  [3:0]  irqFallEn;
    reg  [7:0]  ifcCtrl;
    reg  [2:0]  edgeCnt;
    reg  [15:0] startCnt;
    reg         dirPrev;
    wire        clkRun;
    wire        clkRise;
    wire        cmpIrq;
    wire        phyAwakeBit;
    wire        apbWrite;
    wire        apbSetup;
    wire        wakeDone;
    wire        lowPowerBus;
    wire [3:0]  cmpLevels;

    // Reset release is synchronised so every flop on rstN leaves reset on the same edge
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync <= 2'b00;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end
    assign rstN = rstSync[1];

    function isMapped;
        input [`ULP_ADDR_W-1:0] addr;
        begin
            isMapped = (addr == `ULP_FUNC_CTRL_OFS) || (addr == `ULP_OTG_CTRL_OFS) ||
                       (addr == `ULP_IRQ_RISE_EN_OFS) || (addr == `ULP_IRQ_FALL_EN_OFS) ||
                       (addr == `ULP_IFC_CTRL_OFS) || (addr == `ULP_STATUS_OFS);
        end
    endfunction

    // APB: one wait-free access phase; read data captured in the setup cycle
    assign apbSetup = psel & ~penable;
    assign apbWrite = psel & penable & pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~isMapped(paddr);

    assign phyAwakeBit = funcCtrl[`ULP_FUNC_AWAKE_BIT];
    assign cmpLevels   = {idGroundedCmp, sessionEndCmp, sessionValidCmp, busPowerValidCmp};
    assign wakeDone    = (state == ST_CLKUP) && clkRise &&
                         (edgeCnt == `ULP_WAKE_EDGES - 1);

    always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            funcCtrl  <= `ULP_FUNC_CTRL_RST;
            otgCtrl   <= `ULP_OTG_CTRL_RST;
            irqRiseEn <= `ULP_IRQ_EN_RST;
            irqFallEn <= `ULP_IRQ_EN_RST;
            ifcCtrl   <= `ULP_IFC_CTRL_RST;
        end else begin
            if (apbWrite) begin
                if (paddr == `ULP_FUNC_CTRL_OFS) begin
                    funcCtrl <= pwdata[7:0];
                end else if (paddr == `ULP_OTG_CTRL_OFS) begin
                    otgCtrl <= pwdata[7:0];
                end else if (paddr == `ULP_IRQ_RISE_EN_OFS) begin
                    irqRiseEn <= pwdata[3:0];
                end else if (paddr == `ULP_IRQ_FALL_EN_OFS) begin
                    irqFallEn <= pwdata[3:0];
                end else if (paddr == `ULP_IFC_CTRL_OFS) begin
                    ifcCtrl <= pwdata[7:0];
                end
            end
            // Hardware set wins over a same-cycle software clear
            if (wakeDone) begin
                funcCtrl[`ULP_FUNC_AWAKE_BIT] <= 1'b1;
            end
        end
    end

    always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            prdata <= 32'h00000000;
        end else if (apbSetup) begin
            if (paddr == `ULP_FUNC_CTRL_OFS) begin
                prdata <= {24'h000000, funcCtrl};
            end else if (paddr == `ULP_OTG_CTRL_OFS) begin
                prdata <= {24'h000000, otgCtrl};
            end else if (paddr == `ULP_IRQ_RISE_EN_OFS) begin
                prdata <= {28'h0000000, irqRiseEn};
            end else if (paddr == `ULP_IRQ_FALL_EN_OFS) begin
                prdata <= {28'h0000000, irqFallEn};
            end else if (paddr == `ULP_IFC_CTRL_OFS) begin
                prdata <= {24'h000000, ifcCtrl};
            end else if (paddr == `ULP_STATUS_OFS) begin
                prdata <= {17'h00000, txActive, stpIn, dirOut, cmpIrq, cmpLevels,
                           fsLineState, 2'b00, state};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    assign transceiverSpeedSelect = funcCtrl[`ULP_FUNC_SPEED_LSB+1:`ULP_FUNC_SPEED_LSB];
    assign terminationSelect      = funcCtrl[`ULP_FUNC_TERM_BIT];
    assign opMode                 = funcCtrl[`ULP_FUNC_OPMODE_LSB+1:`ULP_FUNC_OPMODE_LSB];
    assign lineHighZ              = (opMode == `ULP_OPMODE_HIGH_Z);
    assign plusLinePulldownEn     = otgCtrl[`ULP_OTG_DP_PD_BIT];
    assign minusLinePulldownEn    = otgCtrl[`ULP_OTG_DM_PD_BIT];

    // Pull-up off while the reset pin is low or when software disables it
    assign stopPullupEn = chipResetN & ~ifcCtrl[`ULP_IFC_PULLUP_DIS_BIT];

    // Comparators stay powered while either edge enable is set
    assign busPowerCmpEn   = irqRiseEn[`ULP_IRQ_BUSVLD_BIT] |
                             irqFallEn[`ULP_IRQ_BUSVLD_BIT];
    assign sessionEndCmpEn = irqRiseEn[`ULP_IRQ_SESSION_END_CMP_BIT] |
                             irqFallEn[`ULP_IRQ_SESSION_END_CMP_BIT];

    ulp_cmp_irq #(
        .N(4)
    ) uCmpIrq (
        .clk      (ref_clk),
        .rstN     (rstN),
        .capture  (state == ST_SYNC),
        .cmpLevel (cmpLevels),
        .riseEn   (irqRiseEn),
        .fallEn   (irqFallEn),
        .irq      (cmpIrq)
    );

    assign clkRun = (state != ST_LOWPWR) && (state != ST_START);

    ulp_clk_out #(
        .HALF_PERIOD(CLK_HALF_PERIOD)
    ) uClkOut (
        .clk      (ref_clk),
        .rstN     (rstN),
        .run      (clkRun),
        .phyClk   (phyClockOut),
        .riseTick (clkRise)
    );

    assign analogPowerDown = (state == ST_LOWPWR) || (state == ST_START);

    always @* begin
        next_state = state;
        case (state)
            ST_SYNC: begin
                if (!phyAwakeBit && !txActive) begin
                    next_state = ST_ENTRY;
                end
            end
            ST_ENTRY: begin
                if (clkRise && edgeCnt == `ULP_ENTRY_EDGES - 1) begin
                    next_state = ST_LOWPWR;
                end
            end
            ST_LOWPWR: begin
                // Link drive or pull-up both show as STP high here
                if (stpIn) begin
                    next_state = ST_START;
                end
            end
            ST_START: begin
                if (!stpIn) begin
                    next_state = ST_LOWPWR;
                end else if (startCnt == START_CYCLES[15:0] - 16'h0001) begin
                    next_state = ST_CLKUP;
                end
            end
            ST_CLKUP: begin
                if (!stpIn) begin
                    next_state = ST_LOWPWR;
                end else if (wakeDone) begin
                    next_state = ST_WAITSTP;
                end
            end
            ST_WAITSTP: begin
                // Link keeps STP high until it can drive idle
                if (!stpIn) begin
                    next_state = ST_SYNC;
                end
            end
            default: begin
                next_state = ST_SYNC;
            end
        endcase
    end

    always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            state    <= ST_SYNC;
            edgeCnt  <= 3'd0;
            startCnt <= 16'h0000;
            dirOut   <= 1'b0;
        end else begin
            state <= next_state;
            if (next_state != state) begin
                edgeCnt <= 3'd0;
            end else if (clkRise) begin
                edgeCnt <= edgeCnt + 3'd1;
            end
            if (state == ST_START) begin
                startCnt <= startCnt + 16'h0001;
            end else begin
                startCnt <= 16'h0000;
            end
            dirOut <= (next_state != ST_SYNC) && (next_state != ST_WAITSTP);
        end
    end

    // Bus driven one cycle after DIR rises, released in the cycle DIR falls
    always @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            dirPrev  <= 1'b0;
            txActive <= 1'b0;
        end else begin
            dirPrev  <= dirOut;
            // Stale non-idle bus once the link owns it looks like a transmit command;
            // STP may still be high when DIR falls, so decode waits for sync state
            if (stpIn) begin
                txActive <= 1'b0;
            end else if (state == ST_SYNC && !dirOut && !dirPrev &&
                         dataIn[7:6] == `ULP_TXCMD_CODE) begin
                txActive <= 1'b1;
            end
        end
    end

    assign dataOe      = dirOut & dirPrev;
    assign lowPowerBus = (state == ST_LOWPWR) || (state == ST_START);

    // No clock in this path: receiver and comparators reach the pins directly
    assign dataOut = lowPowerBus ? {4'h0, cmpIrq, 1'b0, fsLineState} : 8'h00;
endmodule

// ### tb/ulp_lpc_props.sv
// Concurrent checks on the low power control block ports
`timescale 1ns/1ps
module ulp_lpc_props (
    input wire       ref_clk,
    input wire       reset_n,
    input wire       stpIn,
    input wire       dirOut,
    input wire [7:0] dataOut,
    input wire       dataOe,
    input wire       phyClockOut,
    input wire [1:0] fsLineState,
    input wire       chipResetN,
    input wire       stopPullupEn,
    input wire       txActive
);
    reg [2:0] riseCnt;
    reg [2:0] lowCnt;
    reg       clkQ;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // Saturating counts: only five edges and a few idle cycles matter
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            riseCnt <= 3'h0;
            lowCnt  <= 3'h0;
            clkQ    <= 1'b0;
        end else begin
            clkQ   <= phyClockOut;
            lowCnt <= phyClockOut ? 3'h0 : ((lowCnt == 3'h7) ? lowCnt : lowCnt + 3'h1);
            if (!dirOut)
                riseCnt <= 3'h0;
            else if (phyClockOut && !clkQ && riseCnt != 3'h7)
                riseCnt <= riseCnt + 3'h1;
        end
    end

    a_clk_stop: assert property (dirOut && lowCnt == 3'h3 |-> riseCnt >= 3'h5)
        else $error("clock stopped before five edges");
    a_lp_map: assert property (dataOut[7:4] == 4'h0 && dataOut[2] == 1'b0)
        else $error("reserved bus bits not low");
    a_line_pass: assert property (dataOut[1:0] != 2'h0 |-> dirOut && dataOut[1:0] == fsLineState)
        else $error("line bits differ from receiver");
    a_bus_own: assert property (dataOe |-> dirOut && $past(dirOut))
        else $error("bus driven without turnaround");
    a_wake_order: assert property ($fell(dirOut) |-> $past(stpIn) &&
        ($past(phyClockOut) || $past(phyClockOut, 2)))
        else $error("direction dropped before clock restart");
    a_stp_wake: assert property (dirOut && $rose(stpIn) |-> ##[1:200] (phyClockOut || !stpIn))
        else $error("stop high did not restart clock");
    a_false_res: assert property (dirOut && $fell(stpIn) |=> dirOut [*4])
        else $error("false resume left low power");
    a_pullup_rst: assert property (!chipResetN |-> !stopPullupEn)
        else $error("pull-up on during reset pin low");
    a_tx_stop: assert property (txActive && stpIn |=> !txActive)
        else $error("transmit not ended by stop");

    c_wake: cover property ($fell(dirOut));
    c_irq: cover property (dataOut[3]);
    c_tx: cover property ($rose(txActive));
endmodule

bind ulp_low_power_ctrl ulp_lpc_props ulp_lpc_props_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .stpIn(stpIn), .dirOut(dirOut),
    .dataOut(dataOut), .dataOe(dataOe), .phyClockOut(phyClockOut),
    .fsLineState(fsLineState), .chipResetN(chipResetN),
    .stopPullupEn(stopPullupEn), .txActive(txActive)
);

// ### tb/ulp_link_model.sv
// Behavioural link controller on the far side of the bus
`timescale 1ns/1ps
module ulp_link_model (
    input  wire       ref_clk,
    input  wire       dirOut,
    input  wire       stopPullupEn,
    input  wire       wake,
    input  wire       drop,
    input  wire       hiZ,
    input  wire       stale,
    input  wire [7:0] dataOut,
    output wire       stpIn,
    output wire [7:0] dataIn
);
    reg stpDrv = 1'b0;
    reg dirQ   = 1'b0;
    reg flip   = 1'b0;
    reg [1:0] irqSync = 2'b00;

    // Stop stays high until direction falls, unless a false resume is commanded
    always @(posedge ref_clk) begin
        irqSync <= {irqSync[0], dataOut[3]};
        stpDrv <= wake | (dirOut & !drop & (stpDrv | irqSync[1]));
        dirQ   <= dirOut;
        flip   <= !flip;
    end

    // Tri-stated stop: pull-up level, else a value that never settles
    assign stpIn  = hiZ ? (stopPullupEn | flip) : stpDrv;
    // Released while PHY owns the bus and in turnaround; pull-downs hold it low
    assign dataIn = (dirOut | dirQ) ? 8'h00 : (stale ? 8'h41 : 8'h00);
endmodule

// ### tb/test_ulpi_phy_low_power_control.sv
// Self-checking bench of the low power control block
`timescale 1ns/1ps
module test_ulpi_phy_low_power_control;
    localparam [159:0] RST = {32'h0, 32'hF, 32'hF, 32'h6, 32'h41};
    reg         ref_clk = 1'b0;
    reg         reset_n = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0;
    reg  [1:0]  fsLineState = 2'h1;
    reg         busPowerValidCmp = 1'b0;
    reg         sessionValidCmp = 1'b0;
    reg         sessionEndCmp = 1'b0;
    reg         idGroundedCmp = 1'b0;
    reg         chipResetN = 1'b0;
    reg         wake = 1'b0;
    reg         drop = 1'b0;
    reg         hiZ = 1'b1;
    reg         stale = 1'b0;
    reg  [31:0] rd;
    reg         errQ;
    wire        pready, pslverr, stpIn, dirOut, dataOe, phyClockOut, stopPullupEn;
    wire        busPowerCmpEn, sessionEndCmpEn, lineHighZ, txActive;
    wire [31:0] prdata;
    wire [7:0]  dataIn, dataOut;
    wire [1:0]  opMode;
    integer     error_cnt = 0;
    integer     samples_checked = 0;
    integer     n;
    integer     k;

    ulp_low_power_ctrl #(.CLK_HALF_PERIOD(1), .START_TIME_NS(500)) ulp_low_power_ctrl_i (
        .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .stpIn(stpIn), .dataIn(dataIn),
        .dirOut(dirOut), .dataOut(dataOut), .dataOe(dataOe), .phyClockOut(phyClockOut),
        .fsLineState(fsLineState), .busPowerValidCmp(busPowerValidCmp),
        .sessionValidCmp(sessionValidCmp), .sessionEndCmp(sessionEndCmp),
        .idGroundedCmp(idGroundedCmp), .chipResetN(chipResetN),
        .stopPullupEn(stopPullupEn), .busPowerCmpEn(busPowerCmpEn),
        .sessionEndCmpEn(sessionEndCmpEn), .analogPowerDown(),
        .transceiverSpeedSelect(), .terminationSelect(), .opMode(opMode),
        .lineHighZ(lineHighZ), .plusLinePulldownEn(), .minusLinePulldownEn(),
        .txActive(txActive)
    );

    ulp_link_model ulp_link_model_i (
        .ref_clk(ref_clk), .dirOut(dirOut), .stopPullupEn(stopPullupEn), .wake(wake),
        .drop(drop), .hiZ(hiZ), .stale(stale), .dataOut(dataOut), .stpIn(stpIn),
        .dataIn(dataIn)
    );

    initial forever #5 ref_clk = ~ref_clk;

    task chk(input [31:0] got, input [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Setup cycle, then access held until ready is seen at an edge
    task apb(input w, input [11:0] a, input [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        for (k = 0; k < 20 && pready !== 1'b1; k = k + 1) @(posedge ref_clk);
        if (pready !== 1'b1)
            error_cnt = error_cnt + 1;
        rd      = prdata;
        errQ    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task enter;
        apb(1'b1, 12'h000, 32'h0D);
        for (k = 0; k < 20 && dirOut !== 1'b1; k = k + 1) @(posedge ref_clk);
        chk(dirOut, 1);
        repeat (30) @(posedge ref_clk);
    endtask

    task waitLow;
        for (k = 0; k < 300 && dirOut !== 1'b0; k = k + 1) @(posedge ref_clk);
        chk(dirOut, 0);
    endtask

    task final_report;
        if (error_cnt == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Whole run is a few hundred cycles
    initial begin
        #200000;
        error_cnt = error_cnt + 1;
        final_report;
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        chk(stopPullupEn, 0);
        reset_n    <= 1'b1;
        chipResetN <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk(stopPullupEn, 1);
        hiZ <= 1'b0;
        for (n = 0; n < 5; n = n + 1) begin
            apb(1'b0, {n[9:0], 2'b00}, 32'h0);
            chk(rd, RST[32*n +: 32]);
        end
        apb(1'b0, 12'h020, 32'h0);
        chk(errQ, 1);
        chk(rd, 0);
        apb(1'b1, 12'h010, 32'h80);
        chk(stopPullupEn, 0);
        apb(1'b1, 12'h010, 32'h0);
        chk(stopPullupEn, 1);
        apb(1'b1, 12'h008, 32'hA);
        apb(1'b1, 12'h00C, 32'hA);
        chk({busPowerCmpEn, sessionEndCmpEn}, 0);
        apb(1'b1, 12'h00C, 32'h1);
        chk({busPowerCmpEn, sessionEndCmpEn}, 2);
        apb(1'b1, 12'h00C, 32'h5);
        chk({busPowerCmpEn, sessionEndCmpEn}, 3);
        apb(1'b1, 12'h008, 32'hF);
        apb(1'b1, 12'h000, 32'h4D);
        chk({opMode, lineHighZ}, 3);
        enter;
        chk(dataOut, 32'h01);
        busPowerValidCmp <= 1'b1;
        fsLineState      <= 2'h2;
        @(posedge ref_clk);
        #1;
        chk(dataOut, 32'h0A);
        chk(dataOe, 1);
        wake <= 1'b1;
        @(posedge ref_clk);
        wake <= 1'b0;
        waitLow;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd & 32'h40, 32'h40);
        chk(dataOut, 0);
        enter;
        wake <= 1'b1;
        repeat (10) @(posedge ref_clk);
        wake <= 1'b0;
        drop <= 1'b1;
        repeat (100) @(posedge ref_clk);
        chk({dirOut, phyClockOut}, 2);
        drop  <= 1'b0;
        stale <= 1'b1;
        hiZ   <= 1'b1;
        waitLow;
        hiZ <= 1'b0;
        for (k = 0; k < 20 && txActive !== 1'b1; k = k + 1) @(posedge ref_clk);
        chk(txActive, 1);
        wake <= 1'b1;
        @(posedge ref_clk);
        wake  <= 1'b0;
        stale <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk(txActive, 0);
        final_report;
    end
endmodule
